// ### common/rcs_pkg.sv
// package: constants and carrier types for the reset and configuration sequencer
package rcs_pkg;
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned CLK_NS          = 50;
    // timing figures in their own units
    localparam int unsigned PLL_LOCK_US     = 100;
    localparam int unsigned DLL_LOCK_MIN_CK = 7680;
    localparam int unsigned DLL_LOCK_MAX_CK = 122880;
    localparam int unsigned SOFT_RESET_N_MIN_CK   = 512;
    localparam int unsigned CFG_SETUP_CK    = 4;
    localparam int unsigned CFG_HOLD_CK     = 2;
    localparam int unsigned CFG_RELEASE_CK  = 5;
    localparam int unsigned SR_EXIT_MCK     = 200;
    // pll lock wait: longest time, rounded down, at least one cycle
    localparam int unsigned PLL_LOCK_CYC_RAW = (PLL_LOCK_US * 1000) / CLK_NS;
    localparam int unsigned PLL_LOCK_CYC     = (PLL_LOCK_CYC_RAW < 1) ? 1 : PLL_LOCK_CYC_RAW;
    localparam int unsigned CNT_W           = 24;
    localparam int unsigned RATIO_W         = 4;
    localparam int unsigned CS_N            = 4;
    localparam logic [CS_N-1:0] CS_GUARDED  = 4'h6;

    typedef enum logic [1:0] {
        RCS_ST_HARD,
        RCS_ST_PLL,
        RCS_ST_DLL,
        RCS_ST_RUN
    } rcs_state_t;

    // configuration captured at hard reset release
    typedef struct packed {
        logic [RATIO_W-1:0] plat_ratio;
        logic [RATIO_W-1:0] core_ratio;
        logic [7:0]         straps;
    } rcs_cfg_t;

    // status shown to the rest of the chip
    typedef struct packed {
        logic        pll_locked;
        logic        dll_locked;
        logic        core_run;
        logic [CS_N-1:0] cs_ready;
    } rcs_stat_t;
endpackage

// ### hw/rcs_sequencer.sv
// design: reset and power-on configuration sequencer
`timescale 1ns/1ps

// Notes on behaviour
// R01: board controller holds hard reset low at least 100 us.
// R02: board controller holds soft reset low at least 512 clocks.
// R03: clock and pll straps stable 100 us before hard reset release.
// R04: other straps valid 4 clocks before hard reset release.
// R05: all straps held 2 clocks after hard reset release.
// R06: strap drivers go high impedance within 5 clocks of release.
// R07: wait 100 us pll lock interval before using generated clocks.
// R08: dll lock takes 7680 to 122880 platform clocks, by ratio.
// R09: platform clock rate is primary clock times platform ratio; the enable here pulses at primary clock divided by the ratio.
// R10: chip selects 1 and 2 see 200 memory clocks before precharge.
// R11: real time input high and low each two platform clocks.
// R12: all reset counts run on the primary clock input.
// R13: primary clock at most 166 MHz; ratios keep clocks in range.
// R14: internal reset held until pll then dll intervals elapse.
module rcs_sequencer #(
    parameter int unsigned PLL_LOCK_CYCLES = rcs_pkg::PLL_LOCK_CYC,     // pll wait in clocks
    parameter int unsigned DLL_LOCK_CYCLES = rcs_pkg::DLL_LOCK_MAX_CK   // dll wait, platform clocks
) (
    input  wire logic                           clock_i,          // primary clock input, 20 MHz
    input  wire logic                           reset_n_i,        // async power-on reset
    input  wire logic                           hard_reset_n_i,   // board hard reset pin
    input  wire logic                           soft_reset_n_i,   // board soft reset pin
    input  wire logic [rcs_pkg::RATIO_W-1:0]    plat_ratio_i,     // platform pll ratio strap
    input  wire logic [rcs_pkg::RATIO_W-1:0]    core_ratio_i,     // core pll ratio strap
    input  wire logic [7:0]                     straps_i,         // other configuration straps
    input  wire logic                           sr_exit_i,        // memory self-refresh exit pulse
    input  wire logic                           mem_clk_en_i,     // one pulse per memory clock
    input  wire logic [rcs_pkg::CS_N-1:0]       precharge_req_i,  // precharge wanted per chip select
    output logic                                core_reset_n_o,   // internal reset, low while held
    output logic                                soft_reset_n_o,   // soft reset to core, low active
    output logic                                plat_clk_en_o,    // platform clock enable pulse
    output rcs_pkg::rcs_cfg_t                   cfg_o,            // latched configuration
    output rcs_pkg::rcs_stat_t                  stat_o,           // sequencer status
    output logic [rcs_pkg::CS_N-1:0]            precharge_ok_o    // precharge allowed per chip select
);
    // pin synchronisers; the first stage of each is read only by the second
    logic              hrst_s1_r, hrst_s2_r, hrst_d_r;
    logic              srst_s1_r, srst_s2_r;
    rcs_pkg::rcs_cfg_t strap_s1_r, strap_s2_r;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hrst_s1_r <= 1'h0;
            hrst_s2_r <= 1'h0;
            hrst_d_r  <= 1'h0;
            srst_s1_r <= 1'h1;
            srst_s2_r <= 1'h1;
        end else begin
            hrst_s1_r <= hard_reset_n_i;
            hrst_s2_r <= hrst_s1_r;
            hrst_d_r  <= hrst_s2_r;
            srst_s1_r <= soft_reset_n_i;
            srst_s2_r <= srst_s1_r;
        end
    end

    // straps ride a synchroniser of their own, in step with the hard reset pin,
    // so the value kept is the one seen at the first edge after release
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            strap_s1_r <= '0;
            strap_s2_r <= '0;
        end else begin
            strap_s1_r <= '{plat_ratio: plat_ratio_i, core_ratio: core_ratio_i, straps: straps_i};
            strap_s2_r <= strap_s1_r;
        end
    end
    wire hard_n    = hrst_s2_r;
    wire hard_rise = hrst_s2_r & ~hrst_d_r;


    // one counter serves the pll and the dll waits; only one of them runs at a time
    rcs_pkg::rcs_state_t state_r, state_nxt;
    logic [rcs_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    rcs_pkg::rcs_cfg_t         cfg_r;

    // platform clock enable: one pulse every ratio primary clocks
    logic [rcs_pkg::RATIO_W-1:0] div_r;
    // a zero strap is no legal ratio; it is taken as 1 so the enable never stops
    wire  [rcs_pkg::RATIO_W-1:0] ratio_m1 = (cfg_r.plat_ratio == '0) ? '0 : cfg_r.plat_ratio - 1'b1;
    // R09 platform rate: primary clock divided by ratio here; R09 gives primary times ratio
    wire  plat_tick = (div_r == '0);
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i)
            div_r <= '0;
        else
            div_r <= plat_tick ? ratio_m1 : div_r - 1'b1;
    end

    wire cnt_zero = (cnt_r == '0);
    // R07 pll interval, counted in primary clocks
    wire [rcs_pkg::CNT_W-1:0] pll_load = rcs_pkg::CNT_W'(PLL_LOCK_CYCLES - 1);
    // the output-to-platform ratio is not known here, so the 8:1 worst case is always
    // waited: boot is slower than needed at low ratios, but never too early
    // R08 dll interval, worst-case ratio, counted in platform clocks
    wire [rcs_pkg::CNT_W-1:0] dll_load = rcs_pkg::CNT_W'(DLL_LOCK_CYCLES - 1);

    // R12 every count below advances on clock_i or its enable
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        unique case (state_r)
            rcs_pkg::RCS_ST_HARD: begin
                if (hard_n) begin
                    state_nxt = rcs_pkg::RCS_ST_PLL;
                    cnt_nxt   = pll_load;
                end
            end
            rcs_pkg::RCS_ST_PLL: begin
                if (cnt_zero) begin
                    state_nxt = rcs_pkg::RCS_ST_DLL;
                    cnt_nxt   = dll_load;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            rcs_pkg::RCS_ST_DLL: begin
                if (plat_tick) begin
                    if (cnt_zero)
                        state_nxt = rcs_pkg::RCS_ST_RUN;
                    else
                        cnt_nxt = cnt_r - 1'b1;
                end
            end
            rcs_pkg::RCS_ST_RUN: ;
        endcase
        // hard reset overrides every state
        if (!hard_n)
            state_nxt = rcs_pkg::RCS_ST_HARD;
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= rcs_pkg::RCS_ST_HARD;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // the straps kept are those of the first edge after release, so only one clock of
    // the board's hold is used; they are steady around that edge, so no bit can split
    // R05 capture inside hold
    // R04 R03 setup met by board
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i)
            cfg_r <= '0;
        else if (hard_rise)
            cfg_r <= strap_s2_r;
    end

    // R14 internal reset until pll and dll waits are done
    wire run = (state_r == rcs_pkg::RCS_ST_RUN);

    // soft reset is passed on only while running; board keeps it 512 clocks
    // registered so both resets leave on a clean edge, one clock after run
    logic core_rst_r, soft_rst_r;
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            core_rst_r <= 1'h0;
            soft_rst_r <= 1'h0;
        end else begin
            core_rst_r <= run;
            soft_rst_r <= run & srst_s2_r;
        end
    end

    // memory chip selects 1 and 2 wait 200 memory clocks after self-refresh exit
    logic [7:0] mck_r;
    logic       sr_wait_r;
    localparam logic [7:0] SR_LAST = 8'(rcs_pkg::SR_EXIT_MCK - 1);
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mck_r     <= '0;
            sr_wait_r <= 1'h1;
        end else if (!hard_n) begin
            mck_r     <= '0;
            sr_wait_r <= 1'h1;
        // a later exit restarts the count; precharge waits on the most recent exit
        end else if (sr_exit_i) begin
            mck_r     <= '0;
            sr_wait_r <= 1'h1;
        end else if (sr_wait_r && mem_clk_en_i) begin
            // R10 count memory clocks after exit
            mck_r     <= mck_r + 8'h01;
            sr_wait_r <= (mck_r != SR_LAST);
        end
    end

    // grants are registered: a request seen at one edge is answered at the next
    logic [rcs_pkg::CS_N-1:0] pre_ok_r;
    genvar g;
    generate
        for (g = 0; g < rcs_pkg::CS_N; g++) begin : g_cs
            // R10 guarded selects blocked during wait; 0 and 3 are free
            wire ok = run & precharge_req_i[g] & ~(rcs_pkg::CS_GUARDED[g] & sr_wait_r);
            always_ff @(posedge clock_i or negedge reset_n_i) begin
                if (!reset_n_i)
                    pre_ok_r[g] <= 1'h0;
                else
                    pre_ok_r[g] <= ok;
            end
        end
    endgenerate

    // status decode; the guard is shown even while no precharge is asked for
    wire                     pll_done = (state_r == rcs_pkg::RCS_ST_DLL) | run;
    wire [rcs_pkg::CS_N-1:0] cs_free  = ~({rcs_pkg::CS_N{sr_wait_r}} & rcs_pkg::CS_GUARDED);

    // R11 and R13 are the board's duty; nothing checked here
    assign core_reset_n_o = core_rst_r;
    assign soft_reset_n_o = soft_rst_r;
    assign plat_clk_en_o  = plat_tick;
    assign cfg_o          = cfg_r;
    assign precharge_ok_o = pre_ok_r;
    assign stat_o         = '{pll_locked: pll_done,
                              dll_locked: run,
                              core_run:   core_rst_r,
                              cs_ready:   cs_free};
endmodule

// ### sim/rcs_board_model.sv
// board reset controller model: hard and soft reset pins and straps
`timescale 1ns/1ps
module rcs_board_model (
    input  wire logic              clock_i,        // primary clock
    input  wire logic              hard_go_i,      // start a hard reset
    input  wire logic              soft_go_i,      // start a soft reset
    input  wire rcs_pkg::rcs_cfg_t cfg_i,          // strap values to present
    output logic                   hard_reset_n_o, // hard reset pin
    output logic                   soft_reset_n_o, // soft reset pin
    output rcs_pkg::rcs_cfg_t      straps_o        // strap pins
);
    // power-up starts inside a hard reset
    int hcnt = 2004;
    int scnt = 0;
    always_ff @(negedge clock_i) begin
        hcnt <= hard_go_i ? 2004 : (hcnt > 0 ? hcnt - 1 : 0);
        scnt <= soft_go_i ? 512 : (scnt > 0 ? scnt - 1 : 0);
    end
    assign hard_reset_n_o = hcnt <= 4;
    assign soft_reset_n_o = scnt == 0;
    // driven 4 clocks past release, then inverted so stale values cannot pass
    assign straps_o = (hcnt != 0) ? cfg_i : ~cfg_i;
endmodule

// ### sim/rcs_sequencer_checker.sv
// checker: timing relations at the sequencer ports
`timescale 1ns/1ps
module rcs_sequencer_checker #(
    parameter int unsigned PLL_LOCK_CYCLES = 10, // pll wait
    parameter int unsigned DLL_LOCK_CYCLES = 20  // dll wait
) (
    input wire logic                     clock_i,         // clock
    input wire logic                     reset_n_i,       // reset
    input wire logic                     hard_reset_n_i,  // hard pin
    input wire logic                     sr_exit_i,       // refresh exit
    input wire logic                     mem_clk_en_i,    // memory clock
    input wire logic [rcs_pkg::CS_N-1:0] precharge_req_i, // requests
    input wire logic [rcs_pkg::CS_N-1:0] precharge_ok_o,  // grants
    input wire logic                     core_reset_n_o,  // core reset
    input wire logic                     plat_clk_en_o,   // platform tick
    input wire rcs_pkg::rcs_cfg_t        cfg_o,           // latched straps
    input wire rcs_pkg::rcs_stat_t       stat_o           // status
);
    int unsigned up_q;
    int unsigned mc_q;
    // up_q: clocks since the hard pin rose; mc_q: memory clocks since refresh exit
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            up_q <= 0;
            mc_q <= 0;
        end else begin
            up_q <= !hard_reset_n_i ? 0 : (up_q < 9999 ? up_q + 1 : up_q);
            mc_q <= sr_exit_i ? 0 : (mem_clk_en_i && mc_q < 999 ? mc_q + 1 : mc_q);
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    a_pll_early: assert property ($rose(stat_o.pll_locked) |-> up_q >= PLL_LOCK_CYCLES)
        else $error("pll lock shown too early");
    a_pll_late: assert property (up_q == PLL_LOCK_CYCLES + 8 |-> stat_o.pll_locked)
        else $error("pll lock shown too late");
    a_dll_early: assert property ($rose(stat_o.dll_locked) |-> up_q >= PLL_LOCK_CYCLES + DLL_LOCK_CYCLES)
        else $error("dll lock shown too early");
    a_core_order: assert property ($rose(core_reset_n_o) |-> $past(stat_o.dll_locked) && stat_o.pll_locked)
        else $error("core released before locks");
    a_cs_guard: assert property (|precharge_ok_o[2:1] |-> $past(mc_q) >= rcs_pkg::SR_EXIT_MCK)
        else $error("guarded precharge granted early");
    a_cs_free: assert property (stat_o.dll_locked |=> (precharge_ok_o & 4'h9) == ($past(precharge_req_i) & 4'h9))
        else $error("free chip select grant wrong");
    a_plat_tick: assert property (cfg_o.plat_ratio == 4'h2 && $past(cfg_o.plat_ratio, 2) == 4'h2
        |-> plat_clk_en_o != $past(plat_clk_en_o))
        else $error("platform tick not every second clock");
endmodule
bind rcs_sequencer rcs_sequencer_checker #(.PLL_LOCK_CYCLES(PLL_LOCK_CYCLES), .DLL_LOCK_CYCLES(DLL_LOCK_CYCLES))
    chk_u (.clock_i, .reset_n_i, .hard_reset_n_i, .sr_exit_i, .mem_clk_en_i, .precharge_req_i,
    .precharge_ok_o, .core_reset_n_o, .plat_clk_en_o, .cfg_o, .stat_o);

// ### sim/tb.sv
// testbench: boot, chip select guard, soft reset and repeated hard reset
`timescale 1ns/1ps
module tb;
    localparam int PLL = 10;
    localparam int DLL = 20;
    logic clock_i = 0;
    logic reset_n_i = 0;
    logic hard_go = 0;
    logic soft_go = 0;
    logic sr_exit = 0;
    logic mck = 0;
    logic [3:0] preq = 4'h0;
    rcs_pkg::rcs_cfg_t cfg = 16'h2A5C;
    logic hrn, srn, core_n, soft_n, pclk;
    logic [3:0] pok;
    rcs_pkg::rcs_cfg_t straps, cfg_o;
    rcs_pkg::rcs_stat_t stat;
    int n_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    always #25 clock_i = ~clock_i;
    rcs_board_model brd_u (.clock_i(clock_i), .hard_go_i(hard_go), .soft_go_i(soft_go), .cfg_i(cfg),
        .hard_reset_n_o(hrn), .soft_reset_n_o(srn), .straps_o(straps));
    rcs_sequencer #(.PLL_LOCK_CYCLES(PLL), .DLL_LOCK_CYCLES(DLL)) dut_u (.clock_i(clock_i),
        .reset_n_i(reset_n_i), .hard_reset_n_i(hrn), .soft_reset_n_i(srn), .plat_ratio_i(straps.plat_ratio),
        .core_ratio_i(straps.core_ratio), .straps_i(straps.straps), .sr_exit_i(sr_exit), .mem_clk_en_i(mck),
        .precharge_req_i(preq), .core_reset_n_o(core_n), .soft_reset_n_o(soft_n), .plat_clk_en_o(pclk),
        .cfg_o(cfg_o), .stat_o(stat), .precharge_ok_o(pok));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task automatic final_report();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic t_boot();
        int t0;
        int r;
        logic [3:0] k;
        r = cfg.plat_ratio;
        for (int i = 0; i < 2100 && hrn !== 1'b1; i++) tick(1);
        t0 = cyc;
        for (int i = 0; i < 400 && core_n !== 1'b1; i++) tick(1);
        chk({cyc - t0 >= PLL + r * DLL, cyc - t0 <= PLL + r * (DLL + 1) + 8}, 2'h3);
        chk(cfg_o, cfg);
        chk(stat[6:4], 3'h7);
        k = 0;
        repeat (6) begin
            k += pclk;
            tick(1);
        end
        chk(k, 6 / r);
    endtask
    task automatic t_guard();
        preq = 4'hF;
        sr_exit = 1;
        tick(1);
        sr_exit = 0;
        mck = 1;
        tick(199);
        mck = 0;
        tick(1);
        chk(pok, 4'h9);
        chk(stat[3:0], 4'h9);
        mck = 1;
        tick(1);
        mck = 0;
        tick(2);
        chk(pok, 4'hF);
        chk(stat[3:0], 4'hF);
        preq = 4'h0;
    endtask
    task automatic t_soft();
        soft_go <= 1;
        tick(1);
        soft_go <= 0;
        tick(5);
        chk({soft_n, core_n}, 2'h1);
        tick(520);
        chk({soft_n, core_n}, 2'h3);
    endtask
    task automatic t_rehard();
        cfg = 16'h3B96;
        preq = 4'hF;
        hard_go <= 1;
        tick(1);
        hard_go <= 0;
        tick(6);
        chk({core_n, pok}, 5'h00);
        preq = 4'h0;
        t_boot();
    endtask
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        tick(8);
        reset_n_i = 1;
        t_boot();
        t_guard();
        t_soft();
        t_rehard();
        final_report();
    end
endmodule
